// file: core/gpp_ports.sv
// Purpose: General-purpose I/O ports 3 to 8 with port 4 edge interrupts
// Assumes: Pin inputs synchronous to clk; Avalon-MM slave, 32-bit data
// Notes:   Function
// Function
// - Port 4 data register at index 04
// - Port 4: input, pull-up, push-pull, alternates
// - Port 4 config high/low, reset to input
// - Port 4 input edges: falling, rising, both
// - Port 4 enable high/low and pending registers
// - Enabled edge sets pending, request goes low
// - Port 3 per-pin pull-up enable register
// - Port 3 per-pin open-drain select register
// - Port 5 data register, push-pull, alternates
// - Port 5 config high/low, reset to input
// - Port 6 data, push-pull or open-drain, alternates
// - Port 6 config high/low, reset to input
// - Port 6 pull-up and open-drain registers
// - Port 7 data, push-pull or open-drain output
// - Port 7 config high/low, reset to input
// - Port 8 has six pins only
// - Port 8 config high covers pins 4-5
`timescale 1ns/10ps
`default_nettype none

module gpp_ports
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [gpp_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Pins of ports 4 to 8
    input wire logic [gpp_pkg::NPORT-1:0][7:0] pin_in,
    output gpp_pkg::gpp_pad_type [gpp_pkg::NPORT-1:0] pad,
    // Peripheral alternate functions of ports 4 to 8
    input wire logic [gpp_pkg::NPORT-1:0][7:0] alt_out,
    input wire logic [gpp_pkg::NPORT-1:0][7:0] alt_oe,
    // Port 3 pad controls
    output logic [7:0] port3_pull,
    output logic [7:0] port3_open_drain,
    // Port 4 interrupt request toward the CPU
    output logic port4_irq_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Two bits per pin, four pins per byte
    function automatic logic [1:0] pin_field(
        input logic [7:0] hi,
        input logic [7:0] lo,
        input int n
    );
        logic [7:0] b;
        b = (n >= 4) ? hi : lo;
        return b[2*(n%4) +: 2];
    endfunction

    // Index of the pull-up/open-drain pair of port 4+p, or -1
    function automatic int ext_of(input int p);
        return (p >= 2) ? p - 1 : -1;
    endfunction

    function automatic logic [7:0] pin_mask(input int p);
        return (p == 4) ? gpp_pkg::P8_PIN_MASK : gpp_pkg::ALL_ONES;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gpp_pkg::gpp_state_type q_ff;
    gpp_pkg::gpp_state_type nxt_q;

    logic [7:0] idx;
    logic take_wr;
    logic [7:0] wbyte;
    logic [gpp_pkg::NPORT-1:0][7:0] rd_port;
    logic [7:0] edge_hit;
    logic [7:0] rbyte;

    assign idx = address[gpp_pkg::ADDR_W-1:2];
    // A write commits only at the edge where waitrequest is seen low
    assign take_wr = write && !q_ff.waitreq && byteenable[0];
    assign wbyte = writedata[7:0];

    always_comb
    begin
        logic [1:0] m;
        logic [1:0] es;
        logic [7:0] pend_keep;
        logic [7:0] msk;
        int e;
        m = gpp_pkg::MODE_IN;
        es = gpp_pkg::EDGE_OFF;
        pend_keep = gpp_pkg::ALL_ONES;
        msk = gpp_pkg::ALL_ONES;
        e = 0;
        nxt_q = q_ff;
        rd_port = '0;
        edge_hit = '0;
        rbyte = gpp_pkg::RST_BYTE;

        // --------------------------------------------------------
        // Pin sampling and pad drive
        // --------------------------------------------------------
        nxt_q.pin_now = pin_in;
        nxt_q.pin_old = q_ff.pin_now;
        for (int p = 0; p < gpp_pkg::NPORT; p++)
        begin
            e = ext_of(p);
            msk = pin_mask(p);
            for (int n = 0; n < 8; n++)
            begin
                m = pin_field(q_ff.cfg_hi[p], q_ff.cfg_lo[p], n);
                nxt_q.pad[p].drive[n] = 1'b0;
                nxt_q.pad[p].oe_n[n] = 1'b1;
                nxt_q.pad[p].pull[n] = 1'b0;
                nxt_q.pad[p].alt_sel[n] = 1'b0;
                // Outputs show the latch, everything else the pin
                rd_port[p][n] = (m == gpp_pkg::MODE_OUT) ?
                    q_ff.dat[p][n] : q_ff.pin_now[p][n];
                if (msk[n])
                begin
                    unique case (m)
                        gpp_pkg::MODE_IN, gpp_pkg::MODE_IN_PU:
                        begin
                            // Ports with a pull-up register obey it alone
                            if (e >= 0)
                                nxt_q.pad[p].pull[n] = q_ff.pur[e][n];
                            else
                                nxt_q.pad[p].pull[n] = (m == gpp_pkg::MODE_IN_PU);
                        end
                        gpp_pkg::MODE_OUT:
                        begin
                            if (e >= 0 && q_ff.od[e][n])
                            begin
                                // Open drain pulls low for 0, floats for 1
                                nxt_q.pad[p].oe_n[n] = q_ff.dat[p][n];
                            end
                            else
                            begin
                                nxt_q.pad[p].drive[n] = q_ff.dat[p][n];
                                nxt_q.pad[p].oe_n[n] = 1'b0;
                            end
                        end
                        gpp_pkg::MODE_ALT:
                        begin
                            // Peripheral must enable itself as well
                            nxt_q.pad[p].alt_sel[n] = 1'b1;
                            nxt_q.pad[p].drive[n] = alt_out[p][n];
                            nxt_q.pad[p].oe_n[n] = !alt_oe[p][n];
                        end
                    endcase
                end
            end
        end
        rd_port[4] = rd_port[4] & gpp_pkg::P8_PIN_MASK;

        // --------------------------------------------------------
        // Port 4 edge detection
        // --------------------------------------------------------
        for (int n = 0; n < 8; n++)
        begin
            m = pin_field(q_ff.cfg_hi[0], q_ff.cfg_lo[0], n);
            es = pin_field(q_ff.ien_hi, q_ff.ien_lo, n);
            if (m == gpp_pkg::MODE_IN || m == gpp_pkg::MODE_IN_PU)
            begin
                unique case (es)
                    gpp_pkg::EDGE_OFF:
                        edge_hit[n] = 1'b0;
                    gpp_pkg::EDGE_FALL:
                        edge_hit[n] = q_ff.pin_old[0][n] && !q_ff.pin_now[0][n];
                    gpp_pkg::EDGE_RISE:
                        edge_hit[n] = !q_ff.pin_old[0][n] && q_ff.pin_now[0][n];
                    gpp_pkg::EDGE_BOTH:
                        edge_hit[n] = q_ff.pin_old[0][n] != q_ff.pin_now[0][n];
                endcase
            end
        end

        // --------------------------------------------------------
        // Register read mux
        // --------------------------------------------------------
        unique case (idx)
            gpp_pkg::IDX_P4_DATA: rbyte = rd_port[0];
            gpp_pkg::IDX_P5_DATA: rbyte = rd_port[1];
            gpp_pkg::IDX_P6_DATA: rbyte = rd_port[2];
            gpp_pkg::IDX_P7_DATA: rbyte = rd_port[3];
            gpp_pkg::IDX_P8_DATA: rbyte = rd_port[4];
            gpp_pkg::IDX_P4_IEN_HI: rbyte = q_ff.ien_hi;
            gpp_pkg::IDX_P4_IEN_LO: rbyte = q_ff.ien_lo;
            gpp_pkg::IDX_P4_PEND: rbyte = q_ff.pend;
            gpp_pkg::IDX_P3_PUR: rbyte = q_ff.pur[0];
            gpp_pkg::IDX_P3_OD: rbyte = q_ff.od[0];
            gpp_pkg::IDX_P6_PUR: rbyte = q_ff.pur[1];
            gpp_pkg::IDX_P6_OD: rbyte = q_ff.od[1];
            gpp_pkg::IDX_P7_PUR: rbyte = q_ff.pur[2];
            gpp_pkg::IDX_P7_OD: rbyte = q_ff.od[2];
            gpp_pkg::IDX_P8_PUR: rbyte = q_ff.pur[3];
            gpp_pkg::IDX_P8_OD: rbyte = q_ff.od[3];
            default:
            begin
                // Unmapped indices read zero
                if (idx >= gpp_pkg::IDX_CFG_BASE && idx <= gpp_pkg::IDX_CFG_LAST)
                begin
                    e = int'(idx - gpp_pkg::IDX_CFG_BASE);
                    rbyte = e[0] ? q_ff.cfg_lo[e/2] : q_ff.cfg_hi[e/2];
                end
            end
        endcase

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (take_wr)
        begin
            unique case (idx)
                gpp_pkg::IDX_P4_DATA: nxt_q.dat[0] = wbyte;
                gpp_pkg::IDX_P5_DATA: nxt_q.dat[1] = wbyte;
                gpp_pkg::IDX_P6_DATA: nxt_q.dat[2] = wbyte;
                gpp_pkg::IDX_P7_DATA: nxt_q.dat[3] = wbyte;
                gpp_pkg::IDX_P8_DATA: nxt_q.dat[4] = wbyte & gpp_pkg::P8_PIN_MASK;
                gpp_pkg::IDX_P4_IEN_HI: nxt_q.ien_hi = wbyte;
                gpp_pkg::IDX_P4_IEN_LO: nxt_q.ien_lo = wbyte;
                gpp_pkg::IDX_P4_PEND: pend_keep = wbyte;
                gpp_pkg::IDX_P3_PUR: nxt_q.pur[0] = wbyte;
                gpp_pkg::IDX_P3_OD: nxt_q.od[0] = wbyte;
                gpp_pkg::IDX_P6_PUR: nxt_q.pur[1] = wbyte;
                gpp_pkg::IDX_P6_OD: nxt_q.od[1] = wbyte;
                gpp_pkg::IDX_P7_PUR: nxt_q.pur[2] = wbyte;
                gpp_pkg::IDX_P7_OD: nxt_q.od[2] = wbyte;
                gpp_pkg::IDX_P8_PUR: nxt_q.pur[3] = wbyte & gpp_pkg::P8_PIN_MASK;
                gpp_pkg::IDX_P8_OD: nxt_q.od[3] = wbyte & gpp_pkg::P8_PIN_MASK;
                default:
                begin
                    if (idx >= gpp_pkg::IDX_CFG_BASE && idx <= gpp_pkg::IDX_CFG_LAST)
                    begin
                        e = int'(idx - gpp_pkg::IDX_CFG_BASE);
                        if (e[0])
                            nxt_q.cfg_lo[e/2] = wbyte;
                        else if (e/2 == 4)
                            nxt_q.cfg_hi[4] = wbyte & gpp_pkg::P8_CFG_HI_MASK;
                        else
                            nxt_q.cfg_hi[e/2] = wbyte;
                    end
                end
            endcase
        end

        // --------------------------------------------------------
        // Pending and request; a new edge beats a clear
        // --------------------------------------------------------
        nxt_q.pend = (q_ff.pend & pend_keep) | edge_hit;
        nxt_q.irq_n = ~|nxt_q.pend;

        // --------------------------------------------------------
        // Bus handshake: one wait cycle, then one ready cycle
        // --------------------------------------------------------
        if ((read || write) && q_ff.waitreq)
        begin
            nxt_q.waitreq = 1'b0;
            nxt_q.rdata = {24'h00_0000, rbyte};
        end
        else
        begin
            nxt_q.waitreq = 1'b1;
            nxt_q.rdata = gpp_pkg::RST_WORD;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q_ff <= '0;
            q_ff.waitreq <= 1'b1;
            q_ff.irq_n <= 1'b1;
            for (int p = 0; p < gpp_pkg::NPORT; p++)
                q_ff.pad[p].oe_n <= gpp_pkg::ALL_ONES;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign readdata = q_ff.rdata;
    assign waitrequest = q_ff.waitreq;
    assign pad = q_ff.pad;
    assign port3_pull = q_ff.pur[0];
    assign port3_open_drain = q_ff.od[0];
    assign port4_irq_n = q_ff.irq_n;

endmodule // gpp_ports

`default_nettype wire

// file: include/gpp_pkg.sv
// Purpose: Constants and carrier types of the port 3 to 8 I/O block
// Assumes: Registers are word-aligned indices on Avalon-MM
// Notes:   Port p of the NPORT arrays stands for port 4+p
package gpp_pkg;

    // ------------------------------------------------------------
    // Bus and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int NPORT = 5;
    localparam int NEXT = 4;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_P4_DATA = 8'h04;
    localparam logic [7:0] IDX_P5_DATA = 8'h05;
    localparam logic [7:0] IDX_P6_DATA = 8'h06;
    localparam logic [7:0] IDX_P7_DATA = 8'h07;
    localparam logic [7:0] IDX_P8_DATA = 8'h08;
    localparam logic [7:0] IDX_P4_IEN_HI = 8'h0E;
    localparam logic [7:0] IDX_P4_IEN_LO = 8'h0F;
    localparam logic [7:0] IDX_P4_PEND = 8'h10;
    localparam logic [7:0] IDX_P7_PUR = 8'h1E;
    localparam logic [7:0] IDX_P7_OD = 8'h1F;
    localparam logic [7:0] IDX_P8_PUR = 8'h22;
    localparam logic [7:0] IDX_P8_OD = 8'h23;
    localparam logic [7:0] IDX_P3_PUR = 8'hEE;
    localparam logic [7:0] IDX_P3_OD = 8'hEF;
    localparam logic [7:0] IDX_P6_PUR = 8'hF4;
    localparam logic [7:0] IDX_P6_OD = 8'hF5;
    // Config high of port 4+p at base+2p, low at base+2p+1
    localparam logic [7:0] IDX_CFG_BASE = 8'h30;
    localparam logic [7:0] IDX_CFG_LAST = 8'h39;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] P8_PIN_MASK = 8'h3F;
    localparam logic [7:0] P8_CFG_HI_MASK = 8'h0F;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // ------------------------------------------------------------
    // Two-bit pin modes and port 4 edge selections
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] MODE_IN_PU = 2'h1;
    localparam logic [1:0] MODE_OUT = 2'h2;
    localparam logic [1:0] MODE_ALT = 2'h3;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] oe_n;
        logic [7:0] pull;
        logic [7:0] alt_sel;
    } gpp_pad_type;

    typedef struct packed {
        logic [NPORT-1:0][7:0] dat;
        logic [NPORT-1:0][7:0] cfg_hi;
        logic [NPORT-1:0][7:0] cfg_lo;
        logic [NEXT-1:0][7:0] pur;
        logic [NEXT-1:0][7:0] od;
        logic [7:0] ien_hi;
        logic [7:0] ien_lo;
        logic [7:0] pend;
        logic [NPORT-1:0][7:0] pin_now;
        logic [NPORT-1:0][7:0] pin_old;
        gpp_pad_type [NPORT-1:0] pad;
        logic waitreq;
        logic [31:0] rdata;
        logic irq_n;
    } gpp_state_type;

endpackage

// file: tb/gpp_properties.sv
// Purpose: Concurrent checks on the port 3 to 8 I/O block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of gpp_ports
`timescale 1ns/10ps
`default_nettype none
module gpp_properties
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register bus
    input wire logic [gpp_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins
    input wire logic [gpp_pkg::NPORT-1:0][7:0] pin_in,
    input wire gpp_pkg::gpp_pad_type [gpp_pkg::NPORT-1:0] pad,
    input wire logic [7:0] port3_pull,
    input wire logic [7:0] port3_open_drain,
    input wire logic port4_irq_n
);
    // ------------------------------------------------------------
    // Bus answer, register commits and pin drive
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence commit_s(logic [7:0] idx);
        write && !waitrequest && byteenable[0] && address[9:2] == idx;
    endsequence
    // Pull-up on a pin that the block drives would fight its own output
    logic [7:0] pull_on_out;
    always_comb
    begin
        pull_on_out = 8'h00;
        for (int p = 0; p < gpp_pkg::NPORT; p++)
            pull_on_out = pull_on_out | (pad[p].pull & ~pad[p].oe_n & ~pad[p].alt_sel);
    end
    answer_next_cycle_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in the next cycle");
    answer_one_cycle_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_data_zero_a: assert property (readdata[31:8] == 24'h000000 && (!waitrequest || readdata == 32'h00000000))
        else $error("readdata not zero outside the answer cycle");
    reset_state_a: assert property ($fell(reset) |-> waitrequest && port4_irq_n && pad[0].oe_n == 8'hFF)
        else $error("outputs not at reset values after reset");
    pull_copy_a: assert property (commit_s(gpp_pkg::IDX_P3_PUR) |-> ##2 port3_pull == $past(writedata[7:0], 2))
        else $error("port 3 pull-up output does not follow its register");
    drain_copy_a: assert property (commit_s(gpp_pkg::IDX_P3_OD) |-> ##2 port3_open_drain == $past(writedata[7:0], 2))
        else $error("port 3 open-drain output does not follow its register");
    irq_set_cause_a: assert property ($fell(port4_irq_n) |-> $past(pin_in[0], 2) != $past(pin_in[0], 3))
        else $error("interrupt request without a port 4 pin edge");
    irq_clear_cause_a: assert property ($rose(port4_irq_n) |-> $past(write) && !$past(waitrequest)
        && $past(address[9:2]) == gpp_pkg::IDX_P4_PEND)
        else $error("interrupt request released without a pending write");
    no_pull_driven_a: assert property (pull_on_out == 8'h00)
        else $error("pull-up applied on a driven pin");
    port8_idle_a: assert property (pad[4].oe_n[7:6] == 2'b11 && pad[4].pull[7:6] == 2'b00)
        else $error("absent port 8 pins not idle");
endmodule // gpp_properties
bind gpp_ports gpp_properties u_props (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pad(pad), .port3_pull(port3_pull), .port3_open_drain(port3_open_drain),
    .port4_irq_n(port4_irq_n));
`default_nettype wire

// file: tb/gpp_pins_model.sv
// Purpose: Circuitry outside the port 4 to 8 pins
// Assumes: Outside sources never fight a pin the block drives
// Notes:   An undriven pin without pull-up wanders every cycle
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_model
(
    // Clock
    input wire logic clk,
    // Pads and outside sources
    input wire gpp_pkg::gpp_pad_type [gpp_pkg::NPORT-1:0] pad,
    input wire logic [gpp_pkg::NPORT-1:0][7:0] ext_val,
    input wire logic [gpp_pkg::NPORT-1:0][7:0] ext_en,
    // Pin levels
    output logic [gpp_pkg::NPORT-1:0][7:0] pin_in
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    logic [7:0] float_ff = 8'h55;
    always @(posedge clk)
        float_ff <= ~float_ff;
    always_comb
        for (int p = 0; p < gpp_pkg::NPORT; p++)
            pin_in[p] = (~pad[p].oe_n & pad[p].drive) | (pad[p].oe_n & ext_en[p] & ext_val[p])
                | (pad[p].oe_n & ~ext_en[p] & (pad[p].pull | float_ff));
endmodule // gpp_pins_model
`default_nettype wire

// file: tb/gpp_ports_three_to_eight_bench.sv
// Purpose: Self-checking bench of the port 3 to 8 I/O block
// Assumes: Avalon master waits for waitrequest low
// Notes:   Port 4 pins are always driven from outside, high at start, so they never float
`timescale 1ns/10ps
`default_nettype none
module gpp_ports_three_to_eight_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [gpp_pkg::ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] readdata;
    logic waitrequest;
    logic [gpp_pkg::NPORT-1:0][7:0] pin_in;
    logic [gpp_pkg::NPORT-1:0][7:0] alt_out = '0;
    logic [gpp_pkg::NPORT-1:0][7:0] alt_oe = '0;
    logic [gpp_pkg::NPORT-1:0][7:0] ext_val = 40'h00000000FF;
    logic [gpp_pkg::NPORT-1:0][7:0] ext_en = 40'h00000000FF;
    gpp_pkg::gpp_pad_type [gpp_pkg::NPORT-1:0] pad;
    logic [7:0] p3_pull;
    logic [7:0] p3_od;
    logic irq_n;
    logic [7:0] rd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    gpp_ports DUT (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .pin_in(pin_in), .pad(pad), .alt_out(alt_out), .alt_oe(alt_oe), .port3_pull(p3_pull),
        .port3_open_drain(p3_od), .port4_irq_n(irq_n));
    gpp_pins_model u_pins (.clk(clk), .pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= {idx, 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= {24'h000000, d};
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        chk(what, exp, rd);
    endtask
    task automatic port4_step(input logic [7:0] v, input logic [7:0] exp);
        @(posedge clk);
        ext_val[0] <= v;
        repeat (3) @(posedge clk);
        rd_chk("pending", gpp_pkg::IDX_P4_PEND, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        for (int i = 0; i < 10; i++)
            rd_chk("config", gpp_pkg::IDX_CFG_BASE + 8'(i), 8'h00);
        for (int p = 0; p < gpp_pkg::NPORT; p++)
            chk("oe_n", 8'hFF, pad[p].oe_n);
    endtask
    task automatic t_regs;
        logic [7:0] tab [10] = '{gpp_pkg::IDX_P3_PUR, gpp_pkg::IDX_P3_OD, gpp_pkg::IDX_P6_PUR, gpp_pkg::IDX_P6_OD,
            gpp_pkg::IDX_P7_PUR, gpp_pkg::IDX_P7_OD, gpp_pkg::IDX_P8_PUR, gpp_pkg::IDX_P8_OD,
            gpp_pkg::IDX_P4_IEN_HI, gpp_pkg::IDX_P4_IEN_LO};
        for (int i = 0; i < 10; i++)
        begin
            wr(tab[i], 8'hA5);
            rd_chk("register", tab[i], (i == 6 || i == 7) ? 8'h25 : 8'hA5);
            bus(1'b1, tab[i], 8'h3C, 4'h0);
            rd_chk("lane off", tab[i], (i == 6 || i == 7) ? 8'h25 : 8'hA5);
            wr(tab[i], 8'h00);
        end
        wr(8'h50, 8'hFF);
        rd_chk("unmapped", 8'h50, 8'h00);
    endtask
    task automatic t_output;
        wr(gpp_pkg::IDX_CFG_BASE + 8'h04, 8'hAA);
        wr(gpp_pkg::IDX_CFG_BASE + 8'h05, 8'hAA);
        wr(gpp_pkg::IDX_P6_DATA, 8'h5A);
        repeat (2) @(posedge clk);
        chk("push oe_n", 8'h00, pad[2].oe_n);
        chk("push drive", 8'h5A, pad[2].drive);
        rd_chk("p6 latch", gpp_pkg::IDX_P6_DATA, 8'h5A);
        wr(gpp_pkg::IDX_P6_OD, 8'hFF);
        repeat (2) @(posedge clk);
        chk("drain oe_n", 8'h5A, pad[2].oe_n);
        chk("drain drive", 8'h00, pad[2].drive);
    endtask
    task automatic t_input;
        @(posedge clk);
        ext_val[1] <= 8'hC3;
        ext_en[1] <= 8'hFF;
        repeat (2) @(posedge clk);
        rd_chk("p5 pins", gpp_pkg::IDX_P5_DATA, 8'hC3);
        wr(gpp_pkg::IDX_CFG_BASE, 8'h55);
        wr(gpp_pkg::IDX_CFG_BASE + 8'h01, 8'h55);
        wr(gpp_pkg::IDX_P8_PUR, 8'hFF);
        repeat (2) @(posedge clk);
        chk("p4 pull", 8'hFF, pad[0].pull);
        chk("p8 pull", 8'h3F, pad[4].pull);
    endtask
    task automatic t_irq;
        wr(gpp_pkg::IDX_P4_IEN_LO, 8'h55);
        wr(gpp_pkg::IDX_P4_IEN_HI, 8'hAA);
        wr(gpp_pkg::IDX_P4_PEND, 8'h00);
        chk("irq idle", 1'b1, irq_n);
        port4_step(8'hFE, 8'h01);
        chk("irq low", 1'b0, irq_n);
        port4_step(8'h7E, 8'h01);
        port4_step(8'hFE, 8'h81);
        wr(gpp_pkg::IDX_P4_IEN_LO, 8'hFF);
        port4_step(8'hFA, 8'h85);
        wr(gpp_pkg::IDX_P4_PEND, 8'hFB);
        port4_step(8'hFE, 8'h85);
        wr(gpp_pkg::IDX_P4_PEND, 8'h04);
        rd_chk("cleared", gpp_pkg::IDX_P4_PEND, 8'h04);
        chk("irq held", 1'b0, irq_n);
        wr(gpp_pkg::IDX_P4_IEN_LO, 8'h00);
        wr(gpp_pkg::IDX_P4_PEND, 8'h00);
        port4_step(8'hFF, 8'h00);
        chk("irq released", 1'b1, irq_n);
        rd_chk("p4 pins", gpp_pkg::IDX_P4_DATA, 8'hFF);
    endtask
    task automatic t_alt;
        @(posedge clk);
        alt_out[3] <= 8'h05;
        alt_oe[3] <= 8'h0F;
        wr(gpp_pkg::IDX_CFG_BASE + 8'h07, 8'hFF);
        repeat (2) @(posedge clk);
        chk("alt select", 8'h0F, pad[3].alt_sel);
        chk("alt oe_n", 8'hF0, pad[3].oe_n);
        chk("alt drive", 4'h5, pad[3].drive[3:0]);
        wr(gpp_pkg::IDX_CFG_BASE + 8'h08, 8'hAA);
        wr(gpp_pkg::IDX_CFG_BASE + 8'h09, 8'hAA);
        wr(gpp_pkg::IDX_P8_DATA, 8'hFF);
        rd_chk("p8 cfg high", gpp_pkg::IDX_CFG_BASE + 8'h08, 8'h0A);
        rd_chk("p8 latch", gpp_pkg::IDX_P8_DATA, 8'h3F);
    endtask
    // ------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_regs();
        t_output();
        t_input();
        t_irq();
        t_alt();
        close_out();
    end
endmodule // gpp_ports_three_to_eight_bench
`default_nettype wire
